// ===== common/alu_consts.vh
/*
 Constants of the ALU datapath: register offsets, command fields,
 operation codes, flag positions and divider timing.
 Assumes inclusion by bare name from the core files.
*/
// Operation
// - Sixteen-bit two's complement add, subtract, shift and logic operations.
// - Add and subtract update carry, zero, negative, signed wrap and half carry flags.
// - Subtract sets carry and half carry as inverted borrow and digit borrow.
// - Command byte bit selects 8-bit or 16-bit width for add, subtract and logic operations only.
// - Operands come from working registers or memory; results go to either.
// - Multiplier is 17 by 17 bits for signed, unsigned and mixed products.
// - Multiply modes: ss, uu, us, signed or unsigned by literal, 8x8 uu.
// - Divide 32/16 and 16/16, signed and unsigned.
// - Quotient lands in quotient register, remainder in remainder register.
// - Divisor from operand b register; 32-bit dividend from high and low pair.
// - One cycle per divisor bit, same count for both dividend sizes.
// - Shifter moves up to 15 positions in one cycle.
// - Multi-bit shifts read and write working registers only.
// - Shifts are arithmetic right, left and logical right by n bits.
// - 24-bit program address from program counter, table op or remap.
// - User half only; table ops reach configuration space when page bit 7 set.
// - Program space holds four mega instruction locations.
// - Half carry is carry from bit 3 for bytes, bit 7 for words.
// - Divide takes 19 cycles and may be suspended at any cycle.
// - Multiply completes in one cycle.
`ifndef ALU_CONSTS_VH
`define ALU_CONSTS_VH

// Register byte offsets
`define OFS_OPA 6'h00
`define OFS_OPB 6'h04
`define OFS_CMD 6'h08
`define OFS_STAT 6'h0c
`define OFS_RES 6'h10
`define OFS_RESH 6'h14
`define OFS_QUO 6'h18
`define OFS_REM 6'h1c
`define OFS_DIVH 6'h20
`define OFS_TPAG 6'h24
`define OFS_PC 6'h28
`define OFS_TOFS 6'h2c
`define OFS_PADR 6'h30
`define OFS_ASEL 6'h34

// Command fields
`define CMD_BYTE 4
`define CMD_SRCM 5
`define CMD_DSTM 6
`define CMD_MM_LO 8
`define CMD_MM_HI 10
`define CMD_DSGN 11
`define CMD_DLONG 12

// Operation codes
`define OP_ADD 4'h0
`define OP_SUB 4'h1
`define OP_AND 4'h2
`define OP_OR 4'h3
`define OP_XOR 4'h4
`define OP_ASR 4'h5
`define OP_SL 4'h6
`define OP_LSR 4'h7
`define OP_MUL 4'h8
`define OP_DIV 4'h9

// Multiply modes
`define MUL_SS 3'h0
`define MUL_UU 3'h1
`define MUL_SL 3'h2
`define MUL_UL 3'h3
`define MUL_US 3'h4
`define MUL_B8 3'h5

// Status bits
`define FL_C 0
`define FL_Z 1
`define FL_OV 2
`define FL_N 3
`define FL_DC 8
`define ST_BUSY 16
`define FLAGS_RST 9'h000

// Program address
`define AS_PC 2'h0
`define AS_TRD 2'h1
`define AS_TWR 2'h2
`define AS_PSV 2'h3
`define PA_OK 24
`define PA_CFG 25
`define PC_RST 23'h000000
`define TPAG_RST 8'h00

// Divider steps
`define DIV_STEPS 5'h10

`endif

// ===== core/div_iter.v
/*
 Iterative divider: magnitude setup, sixteen restoring steps,
 sign fix and result cycle. Assumes start only while idle.
*/
`include "alu_consts.vh"

module div_iter (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Request
    input wire start_i,
    input wire hold_i,
    input wire signed_i,
    input wire [31:0] dvd_i,
    input wire [15:0] dvs_i,
    // Answer
    output wire busy_o,
    output reg done_o,
    output reg [15:0] quo_o,
    output reg [15:0] rem_o
);

localparam S_IDLE = 3'h0;
localparam S_SETUP = 3'h1;
localparam S_STEP = 3'h2;
localparam S_FIX = 3'h3;
localparam S_DONE = 3'h4;

reg [2:0] st_r;
reg [4:0] cnt_r;
reg [31:0] dvd_r;
reg [15:0] dvs_r;
reg sgn_r;
reg negq_r;
reg negr_r;
reg [16:0] r_r;
reg [15:0] q_r;
reg [15:0] d_r;

wire [31:0] dvd_mag = (sgn_r & dvd_r[31]) ? (~dvd_r + 32'h00000001) : dvd_r;
wire [15:0] dvs_mag = (sgn_r & dvs_r[15]) ? (~dvs_r + 16'h0001) : dvs_r;
wire [16:0] sh = {r_r[15:0], q_r[15]};
wire take = sh >= {1'b0, d_r};
wire [16:0] sub = sh - {1'b0, d_r};

assign busy_o = (st_r != S_IDLE);

////////////////////////////////////////////////////////////////////////
// Divide sequence, frozen while held
always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        st_r <= S_IDLE;
        cnt_r <= 5'h00;
        dvd_r <= 32'h00000000;
        dvs_r <= 16'h0000;
        sgn_r <= 1'b0;
        negq_r <= 1'b0;
        negr_r <= 1'b0;
        r_r <= 17'h00000;
        q_r <= 16'h0000;
        d_r <= 16'h0000;
        done_o <= 1'b0;
        quo_o <= 16'h0000;
        rem_o <= 16'h0000;
    end else begin
        done_o <= 1'b0;
        if (st_r == S_IDLE) begin
            if (start_i) begin
                dvd_r <= dvd_i;
                dvs_r <= dvs_i;
                sgn_r <= signed_i;
                st_r <= S_SETUP;
            end
        end else if (!hold_i) begin
            case (st_r)
                S_SETUP: begin
                    r_r <= {1'b0, dvd_mag[31:16]};
                    q_r <= dvd_mag[15:0];
                    d_r <= dvs_mag;
                    negq_r <= sgn_r & (dvd_r[31] ^ dvs_r[15]);
                    negr_r <= sgn_r & dvd_r[31];
                    cnt_r <= 5'h00;
                    st_r <= S_STEP;
                end
                S_STEP: begin
                    r_r <= take ? sub : sh;
                    q_r <= {q_r[14:0], take};
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == `DIV_STEPS - 5'h01) begin
                        st_r <= S_FIX;
                    end
                end
                S_FIX: begin
                    q_r <= negq_r ? (~q_r + 16'h0001) : q_r;
                    r_r <= negr_r ? {1'b0, ~r_r[15:0] + 16'h0001} : r_r;
                    st_r <= S_DONE;
                end
                default: begin
                    quo_o <= q_r;
                    rem_o <= r_r[15:0];
                    done_o <= 1'b1;
                    st_r <= S_IDLE;
                end
            endcase
        end
    end
end

endmodule

// ===== core/alu_core.v
/*
 ALU datapath with multiplier, shifter, divider and program
 address former, reached over an Avalon-MM slave.
 Assumes operand memory data from logic on the same clock.
*/
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`include "alu_consts.vh"

module alu_core (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Avalon-MM slave
    input wire [5:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    // Operand memory and divide suspend
    input wire [15:0] mem_rdata_i,
    input wire div_hold_i,
    // Result write back
    output reg [15:0] wb_data_o,
    output reg wb_wreg_o,
    output reg wb_mem_o,
    // Program address
    output reg [23:0] prog_addr_o,
    output reg prog_ok_o,
    output reg prog_cfg_o
);

////////////////////////////////////////////////////////////////////////
// Registers
reg [15:0] opa_r;
reg [15:0] opb_r;
reg [15:0] res_r;
reg [15:0] resh_r;
reg [15:0] divh_r;
reg [15:0] quo_r;
reg [15:0] rem_r;
reg [8:0] alu_status_register;
reg [7:0] table_page_register;
reg [22:0] program_counter;
reg [15:0] tofs_r;
reg [1:0] asel_r;
reg ack_r;
reg [31:0] rdata_r;

wire req = avs_read_i | avs_write_i;
wire [15:0] wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
wire [15:0] wd = avs_writedata_i[15:0];
wire is_cmd = (avs_address_i == `OFS_CMD);
wire div_busy;

// Command write waits while a divide runs, unacknowledged until idle
wire blk = avs_write_i & is_cmd & div_busy;
assign avs_waitrequest_o = req & (~ack_r | blk);
assign avs_readdata_o = rdata_r;

wire acc = req & ~avs_waitrequest_o;
wire wr = acc & avs_write_i;
wire exec = wr & is_cmd;

// Masked lane merge
function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input [15:0] m;
    begin
        merge = (old & ~m) | (nw & m);
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Command decode
wire [3:0] op = wd[3:0];
wire byte_m = wd[`CMD_BYTE] & (op <= `OP_XOR);
wire is_sh = (op == `OP_ASR) | (op == `OP_SL) | (op == `OP_LSR);
wire src_m = wd[`CMD_SRCM] & ~is_sh;
wire dst_m = wd[`CMD_DSTM] & ~is_sh;
wire [2:0] mmode = wd[`CMD_MM_HI:`CMD_MM_LO];
wire [15:0] a = opa_r;
wire [15:0] b = src_m ? mem_rdata_i : opb_r;

////////////////////////////////////////////////////////////////////////
// Adder, subtract as a plus inverted b plus one
wire sub_op = (op == `OP_SUB);
wire [15:0] bb = sub_op ? ~b : b;
wire cin = sub_op;
wire [4:0] s4 = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
wire [8:0] s8 = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, cin};
wire [16:0] s16 = {1'b0, a} + {1'b0, bb} + {16'h0000, cin};
wire [15:0] sum = byte_m ? {a[15:8], s8[7:0]} : s16[15:0];
// Carry out is inverted borrow on subtract
wire c_add = byte_m ? s8[8] : s16[16];
wire dc_add = byte_m ? s4[4] : s8[8];
wire ov_b = (a[7] == bb[7]) & (s8[7] != a[7]);
wire ov_w = (a[15] == bb[15]) & (s16[15] != a[15]);
wire ov_add = byte_m ? ov_b : ov_w;

////////////////////////////////////////////////////////////////////////
// Logic unit
reg [15:0] lg;
always @* begin
    case (op)
        `OP_AND: lg = a & b;
        `OP_OR: lg = a | b;
        default: lg = a ^ b;
    endcase
end
wire [15:0] lgr = byte_m ? {a[15:8], lg[7:0]} : lg;

////////////////////////////////////////////////////////////////////////
// Barrel shifter, extra bit catches the last bit out
wire [3:0] sa = b[3:0];
wire [16:0] asr17 = $signed({a, 1'b0}) >>> sa;
wire [16:0] lsr17 = {a, 1'b0} >> sa;
wire [16:0] sl17 = {1'b0, a} << sa;
reg [15:0] shr;
reg shc;
always @* begin
    case (op)
        `OP_ASR: begin
            shr = asr17[16:1];
            shc = asr17[0];
        end
        `OP_SL: begin
            shr = sl17[15:0];
            shc = sl17[16];
        end
        default: begin
            shr = lsr17[16:1];
            shc = lsr17[0];
        end
    endcase
end

////////////////////////////////////////////////////////////////////////
// 17 by 17 multiplier with sign extension per mode
reg [16:0] ma;
reg [16:0] mb;
always @* begin
    case (mmode)
        `MUL_SS: begin
            ma = {a[15], a};
            mb = {b[15], b};
        end
        `MUL_UU: begin
            ma = {1'b0, a};
            mb = {1'b0, b};
        end
        `MUL_SL: begin
            ma = {a[15], a};
            mb = {12'h000, b[4:0]};
        end
        `MUL_UL: begin
            ma = {1'b0, a};
            mb = {12'h000, b[4:0]};
        end
        `MUL_US: begin
            ma = {1'b0, a};
            mb = {b[15], b};
        end
        default: begin
            ma = {9'h000, a[7:0]};
            mb = {9'h000, b[7:0]};
        end
    endcase
end
wire signed [33:0] prod = $signed(ma) * $signed(mb);

////////////////////////////////////////////////////////////////////////
// Result select and flag update
reg [15:0] alu_res;
reg [8:0] fl_nxt;
wire rmsb = byte_m ? alu_res[7] : alu_res[15];
wire rzero = byte_m ? (alu_res[7:0] == 8'h00) : (alu_res == 16'h0000);
always @* begin
    alu_res = sum;
    fl_nxt = alu_status_register;
    case (op)
        `OP_ADD, `OP_SUB: begin
            alu_res = sum;
            fl_nxt[`FL_C] = c_add;
            fl_nxt[`FL_DC] = dc_add;
            fl_nxt[`FL_OV] = ov_add;
            fl_nxt[`FL_N] = rmsb;
            fl_nxt[`FL_Z] = rzero;
        end
        `OP_AND, `OP_OR, `OP_XOR: begin
            alu_res = lgr;
            fl_nxt[`FL_N] = rmsb;
            fl_nxt[`FL_Z] = rzero;
        end
        `OP_ASR, `OP_SL, `OP_LSR: begin
            alu_res = shr;
            fl_nxt[`FL_C] = shc;
            fl_nxt[`FL_N] = rmsb;
            fl_nxt[`FL_Z] = rzero;
        end
        default: begin
            alu_res = prod[15:0];
        end
    endcase
end

////////////////////////////////////////////////////////////////////////
// Divider
wire [31:0] dvd = wd[`CMD_DLONG] ? {divh_r, opa_r} :
    (wd[`CMD_DSGN] ? {{16{opa_r[15]}}, opa_r} : {16'h0000, opa_r});
wire dv_done;
wire [15:0] dv_q;
wire [15:0] dv_r;

div_iter u_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(exec & (op == `OP_DIV)),
    .hold_i(div_hold_i),
    .signed_i(wd[`CMD_DSGN]),
    .dvd_i(dvd),
    .dvs_i(opb_r),
    .busy_o(div_busy),
    .done_o(dv_done),
    .quo_o(dv_q),
    .rem_o(dv_r)
);

////////////////////////////////////////////////////////////////////////
// Program address former
reg [23:0] padr;
wire tbl = (asel_r == `AS_TRD) | (asel_r == `AS_TWR);
always @* begin
    case (asel_r)
        `AS_PC: padr = {1'b0, program_counter};
        `AS_PSV: padr = {1'b0, table_page_register[6:0], tofs_r};
        default: padr = {table_page_register, tofs_r};
    endcase
end

// Registered address outputs
always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        prog_addr_o <= 24'h000000;
        prog_ok_o <= 1'b0;
        prog_cfg_o <= 1'b0;
    end else begin
        prog_addr_o <= padr;
        prog_ok_o <= ~padr[23] | tbl;
        prog_cfg_o <= padr[23] & tbl;
    end
end

////////////////////////////////////////////////////////////////////////
// Bus handshake and read data
always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        ack_r <= 1'b0;
        rdata_r <= 32'h00000000;
    end else begin
        ack_r <= req & ~ack_r & ~blk;
        if (avs_read_i & ~ack_r) begin
            if (avs_address_i == `OFS_OPA) begin
                rdata_r <= {16'h0000, opa_r};
            end else if (avs_address_i == `OFS_OPB) begin
                rdata_r <= {16'h0000, opb_r};
            end else if (avs_address_i == `OFS_STAT) begin
                rdata_r <= {15'h0000, div_busy, 7'h00, alu_status_register};
            end else if (avs_address_i == `OFS_RES) begin
                rdata_r <= {16'h0000, res_r};
            end else if (avs_address_i == `OFS_RESH) begin
                rdata_r <= {16'h0000, resh_r};
            end else if (avs_address_i == `OFS_QUO) begin
                rdata_r <= {16'h0000, quo_r};
            end else if (avs_address_i == `OFS_REM) begin
                rdata_r <= {16'h0000, rem_r};
            end else if (avs_address_i == `OFS_DIVH) begin
                rdata_r <= {16'h0000, divh_r};
            end else if (avs_address_i == `OFS_TPAG) begin
                rdata_r <= {24'h000000, table_page_register};
            end else if (avs_address_i == `OFS_PC) begin
                rdata_r <= {9'h000, program_counter};
            end else if (avs_address_i == `OFS_TOFS) begin
                rdata_r <= {16'h0000, tofs_r};
            end else if (avs_address_i == `OFS_PADR) begin
                rdata_r <= {6'h00, prog_cfg_o, prog_ok_o, prog_addr_o};
            end else if (avs_address_i == `OFS_ASEL) begin
                rdata_r <= {30'h00000000, asel_r};
            end else begin
                rdata_r <= 32'h00000000;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Register writes, execution and write back
always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        opa_r <= 16'h0000;
        opb_r <= 16'h0000;
        res_r <= 16'h0000;
        resh_r <= 16'h0000;
        divh_r <= 16'h0000;
        quo_r <= 16'h0000;
        rem_r <= 16'h0000;
        alu_status_register <= `FLAGS_RST;
        table_page_register <= `TPAG_RST;
        program_counter <= `PC_RST;
        tofs_r <= 16'h0000;
        asel_r <= `AS_PC;
        wb_data_o <= 16'h0000;
        wb_wreg_o <= 1'b0;
        wb_mem_o <= 1'b0;
    end else begin
        wb_wreg_o <= 1'b0;
        wb_mem_o <= 1'b0;
        if (wr) begin
            if (avs_address_i == `OFS_OPA) begin
                opa_r <= merge(opa_r, wd, wmask);
            end else if (avs_address_i == `OFS_OPB) begin
                opb_r <= merge(opb_r, wd, wmask);
            end else if (avs_address_i == `OFS_STAT) begin
                alu_status_register <= {avs_byteenable_i[1] ? wd[8] : alu_status_register[8],
                    avs_byteenable_i[0] ? {4'h0, wd[3:0]} : alu_status_register[7:0]};
            end else if (avs_address_i == `OFS_DIVH) begin
                divh_r <= merge(divh_r, wd, wmask);
            end else if (avs_address_i == `OFS_TPAG) begin
                if (avs_byteenable_i[0]) begin
                    table_page_register <= wd[7:0];
                end
            end else if (avs_address_i == `OFS_PC) begin
                // Instruction aligned: 2^22 instruction slots
                program_counter <= {avs_writedata_i[22:1], 1'b0};
            end else if (avs_address_i == `OFS_TOFS) begin
                tofs_r <= merge(tofs_r, wd, wmask);
            end else if (avs_address_i == `OFS_ASEL) begin
                if (avs_byteenable_i[0]) begin
                    asel_r <= wd[1:0];
                end
            end
        end
        if (exec & (op <= `OP_LSR)) begin
            res_r <= alu_res;
            alu_status_register <= fl_nxt;
            wb_data_o <= alu_res;
            wb_wreg_o <= ~dst_m;
            wb_mem_o <= dst_m;
        end
        if (exec & (op == `OP_MUL)) begin
            res_r <= prod[15:0];
            resh_r <= prod[31:16];
        end
        if (dv_done) begin
            quo_r <= dv_q;
            rem_r <= dv_r;
        end
    end
end

endmodule

// ===== dv/far_side_model.sv
/*
 Far side model: memory operand and divide suspend.
 Assumes triggers change right after a rising edge.
*/
module far_side_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Bench control
    input wire logic opnd_vld_i,
    input wire logic [15:0] opnd_i,
    input wire logic hold_go_i,
    input wire logic [3:0] hold_len_i,
    // Towards the core
    output logic [15:0] mem_rdata_o,
    output logic div_hold_o
);
    logic [3:0] left_r;
    logic go_r;
    logic [15:0] junk_r;
    ////////////////////////////////////////////////////////////////
    // Suspend counter and moving junk pattern
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left_r <= 4'h0;
            go_r <= 1'b0;
            junk_r <= 16'h5a5a;
        end else begin
            go_r <= hold_go_i;
            junk_r <= ~junk_r ^ {junk_r[14:0], junk_r[15]};
            if (hold_go_i && !go_r) begin
                left_r <= hold_len_i;
            end else if (left_r != 4'h0) begin
                left_r <= left_r - 4'h1;
            end
        end
    end
    // Operand only while wanted, junk otherwise
    assign div_hold_o = (left_r != 4'h0);
    assign mem_rdata_o = opnd_vld_i ? opnd_i : junk_r;
endmodule

// ===== dv/alu_core_monitor.sv
/*
 Checker on alu_core ports, bound below.
 Assumes one clock, async active-low reset.
*/
`include "alu_consts.vh"
module alu_core_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Bus
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic avs_waitrequest_o,
    // Results
    input wire logic wb_wreg_o,
    input wire logic wb_mem_o,
    input wire logic [23:0] prog_addr_o,
    input wire logic prog_ok_o,
    input wire logic prog_cfg_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Request, command and accept helpers
    wire req = avs_read_i || avs_write_i;
    wire cmd_wr = avs_write_i && avs_address_i == `OFS_CMD;
    wire cmd_acc = cmd_wr && !avs_waitrequest_o;
    sequence div_take; cmd_acc && avs_writedata_i[3:0] == `OP_DIV; endsequence
    sequence shift_take; cmd_acc && avs_writedata_i[3:0] >= `OP_ASR && avs_writedata_i[3:0] <= `OP_LSR; endsequence
    sequence cmd_req; cmd_wr; endsequence
    ////////////////////////////////////////////////////////////////
    chk_wait_first: assert property (req && !$past(req) |-> avs_waitrequest_o)
        else $error("new request not held off");
    chk_wait_one: assert property (req && avs_waitrequest_o && !cmd_wr |=> !avs_waitrequest_o)
        else $error("access longer than one wait");
    chk_idle_free: assert property (!req |-> !avs_waitrequest_o)
        else $error("wait raised with no request");
    chk_wb_excl: assert property (!(wb_wreg_o && wb_mem_o))
        else $error("both result targets at once");
    chk_wb_pulse: assert property ((wb_wreg_o || wb_mem_o) |=> !(wb_wreg_o || wb_mem_o))
        else $error("write back longer than one cycle");
    chk_wb_cause: assert property ($rose(wb_wreg_o || wb_mem_o) |-> $past(cmd_acc))
        else $error("write back without command");
    chk_div_block: assert property (div_take ##[1:18] cmd_req |-> avs_waitrequest_o)
        else $error("command taken during divide");
    chk_shift_reg: assert property (shift_take |=> !wb_mem_o)
        else $error("shift result sent to memory");
    chk_cfg_top: assert property (prog_cfg_o |-> prog_ok_o && prog_addr_o[23])
        else $error("config flag without top half address");
    chk_user_half: assert property (prog_ok_o && !prog_cfg_o |-> !prog_addr_o[23])
        else $error("user access above lower half");
endmodule
bind alu_core alu_core_monitor i_alu_core_monitor (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_waitrequest_o, .wb_wreg_o, .wb_mem_o, .prog_addr_o, .prog_ok_o,
    .prog_cfg_o);

// ===== dv/alu_core_tb.sv
/*
 Bench for alu_core: bus tasks and access sequences.
 Assumes the far side model feeds operands and holds.
*/
`include "alu_consts.vh"
module alu_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] MEXP [6] = '{32'h2, 32'hfffd0002, 32'hffffffe2, 32'h1dffe2, 32'hfffe0002, 32'hfd02};
    localparam logic [15:0] SEXP [6] = '{16'hffff, 16'h8000, 16'h1, 16'hf800, 16'h10, 16'h800};
    localparam logic [15:0] LEXP [3] = '{16'hf000, 16'hfff0, 16'h0ff0};
    logic clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic opnd_vld = 1'b0, hold_go = 1'b0;
    logic [5:0] avs_address_i = 6'h00;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
    logic [15:0] opnd = 16'h0, mem_rdata_i, wb_data_o;
    logic [3:0] hold_len = 4'h0;
    logic avs_waitrequest_o, div_hold_i, wb_wreg_o, wb_mem_o, prog_ok_o, prog_cfg_o;
    logic [23:0] prog_addr_o;
    int err_total = 0, n_compared = 0, cyc = 0, acc_cyc = 0, n_wreg = 0, n_wmem = 0;
    alu_core i_alu_core (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o, .mem_rdata_i, .div_hold_i, .wb_data_o,
        .wb_wreg_o, .wb_mem_o, .prog_addr_o, .prog_ok_o, .prog_cfg_o);
    far_side_model i_far_side_model (.clk_i, .rst_n_i, .opnd_vld_i(opnd_vld), .opnd_i(opnd), .hold_go_i(hold_go),
        .hold_len_i(hold_len), .mem_rdata_o(mem_rdata_i), .div_hold_o(div_hold_i));
    ////////////////////////////////////////////////////////////////
    // Clock
    always #5 clk_i = ~clk_i;
    // Cycle count, write back tallies and hang limit
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (wb_wreg_o === 1'b1) n_wreg <= n_wreg + 1;
        if (wb_mem_o === 1'b1) n_wmem <= n_wmem + 1;
        if (cyc == 6000) begin
            err_total++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////
    task close_out();
        if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One access, held until waitrequest low at a rising edge
    task bus(input logic we, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= we;
        avs_read_i <= !we;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        acc_cyc = cyc;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task rd(input string nm, input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, exp, q);
    endtask
    task op(input logic [15:0] a, input logic [15:0] b, input logic [31:0] c);
        wr(`OFS_OPA, {16'h0, a});
        wr(`OFS_OPB, {16'h0, b});
        wr(`OFS_CMD, c);
    endtask
    // Divide, then a held-off command; span in cycles
    task div_run(input logic [31:0] c, input logic [3:0] hl, output int d);
        int t0;
        wr(`OFS_CMD, c);
        t0 = acc_cyc;
        hold_len <= hl;
        hold_go <= 1'b1;
        wr(`OFS_CMD, 32'ha);
        hold_go <= 1'b0;
        d = acc_cyc - t0;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        int d16, d32, dh, n0, n1;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd("status reset", `OFS_STAT, 32'h0);
        rd("address reset", `OFS_PADR, 32'h1000000);
        // Add and subtract flags
        op(16'h7fff, 16'h1, {28'h0, `OP_ADD});
        rd("add result", `OFS_RES, 32'h8000);
        rd("add flags", `OFS_STAT, 32'h10c);
        op(16'h0, 16'h1, {28'h0, `OP_SUB});
        rd("sub result", `OFS_RES, 32'hffff);
        rd("sub borrow flags", `OFS_STAT, 32'h8);
        op(16'h5, 16'h5, {28'h0, `OP_SUB});
        rd("sub equal flags", `OFS_STAT, 32'h103);
        op(16'h120f, 16'h1, 32'h10);
        rd("byte add result", `OFS_RES, 32'h1210);
        rd("byte add flags", `OFS_STAT, 32'h100);
        // Memory operand and destination
        n0 = n_wmem;
        opnd <= 16'h3;
        opnd_vld <= 1'b1;
        op(16'h4, 16'h9999, 32'h60);
        opnd_vld <= 1'b0;
        rd("memory operand add", `OFS_RES, 32'h7);
        chk("memory writes", n0 + 1, n_wmem);
        chk("write back data", 32'h7, {16'h0, wb_data_o});
        for (int i = 0; i < 3; i++) begin
            op(16'hf0f0, 16'hff00, {28'h0, 4'(`OP_AND + i)});
            rd("logic result", `OFS_RES, {16'h0, LEXP[i]});
        end
        // Shifts with memory bits set
        n0 = n_wreg;
        n1 = n_wmem;
        for (int j = 0; j < 2; j++) begin
            for (int i = 0; i < 3; i++) begin
                op(16'h8001, {12'h0, (j == 1) ? 4'h4 : 4'hf}, {28'h6, 4'(`OP_ASR + i)});
                rd("shift result", `OFS_RES, {16'h0, SEXP[j * 3 + i]});
            end
        end
        chk("shift register writes", n0 + 6, n_wreg);
        chk("shift memory writes", n1, n_wmem);
        for (int m = 0; m < 6; m++) begin
            op(16'hffff, 16'hfffe, {21'h0, 3'(m), 4'h0, `OP_MUL});
            rd("product low", `OFS_RES, {16'h0, MEXP[m][15:0]});
            rd("product high", `OFS_RESH, {16'h0, MEXP[m][31:16]});
        end
        // 16/16, signed 32/16, suspended divides
        wr(`OFS_OPA, 32'd100);
        wr(`OFS_OPB, 32'd7);
        div_run(32'h9, 4'h0, d16);
        rd("quotient", `OFS_QUO, 32'he);
        rd("remainder", `OFS_REM, 32'h2);
        wr(`OFS_DIVH, 32'hffff);
        wr(`OFS_OPA, 32'hff9c);
        div_run(32'h1809, 4'h0, d32);
        rd("signed quotient", `OFS_QUO, 32'hfff2);
        rd("signed remainder", `OFS_REM, 32'hfffe);
        chk("divide span equal", d16, d32);
        chk("divide span bound", 32'h1, {31'h0, d16 >= 19 && d16 <= 24});
        div_run(32'h9, 4'h3, dh);
        chk("suspended span", d16 + 3, dh);
        rd("suspended quotient", `OFS_QUO, 32'h2484);
        // Program addresses
        wr(`OFS_PC, 32'h101);
        rd("counter address", `OFS_PADR, 32'h1000100);
        chk("address port", 32'h100, {8'h0, prog_addr_o});
        wr(`OFS_TPAG, 32'h80);
        wr(`OFS_TOFS, 32'h4);
        for (int s = 1; s < 3; s++) begin
            wr(`OFS_ASEL, s);
            rd("table config address", `OFS_PADR, 32'h03800004);
        end
        wr(`OFS_ASEL, 32'h3);
        rd("remap address", `OFS_PADR, 32'h1000004);
        wr(`OFS_TPAG, 32'h12);
        wr(`OFS_ASEL, 32'h1);
        rd("table user address", `OFS_PADR, 32'h1120004);
        rd("unmapped read", 6'h3c, 32'h0);
        close_out();
    end
endmodule
